// [inc/fgc_pkg.sv]
// package for the gate-controlled frequency counter: register map, fields, timing
// assumes a single 50 MHz clock domain
package fgc_pkg;
  // ==========================================================
  // register map (peripheral addresses)
  localparam logic [7:0] ADDR_GATE_PIN_SEL  = 8'h20;
  localparam logic [7:0] ADDR_MODE_SEL      = 8'h22;
  localparam logic [7:0] ADDR_COUNTER_CTRL  = 8'h23;
  localparam logic [7:0] ADDR_GATE_STATUS   = 8'h24;
  localparam logic [7:0] ADDR_COUNT_VALUE   = 8'h43;

  // ==========================================================
  // fields
  localparam int BIT_CLEAR    = 0;
  localparam int BIT_START    = 1;
  localparam int BIT_SEL_LO   = 0;
  localparam int BIT_SEL_HI   = 1;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic [15:0] CNT_ZERO  = 16'h0000;

  // gate pin selection codes
  localparam logic [1:0] PIN_NONE = 2'h0;
  localparam logic [1:0] PIN_ZERO = 2'h1;
  localparam logic [1:0] PIN_ONE  = 2'h2;

  // function select (mode bits 3:2)
  localparam logic [1:0] FN_EXT_GATE   = 2'h0;
  localparam logic [1:0] FN_DIRECT     = 2'h1;
  localparam logic [1:0] FN_HALVED     = 2'h2;
  localparam logic [1:0] FN_DIRECT_ALT = 2'h3;

  // gate time / reference select (mode bits 1:0)
  localparam logic [1:0] CK_1MS  = 2'h0;
  localparam logic [1:0] CK_4MS  = 2'h1;
  localparam logic [1:0] CK_8MS  = 2'h2;
  localparam logic [1:0] CK_OPEN = 2'h3;

  // ==========================================================
  // timing
  localparam int CLK_HZ       = 50_000_000;
  localparam int TICK_HZ      = 1_000;
  localparam int TICK_CYCLES  = CLK_HZ / TICK_HZ;
  localparam int GATE_1_MS    = 1;
  localparam int GATE_4_MS    = 4;
  localparam int GATE_8_MS    = 8;
  localparam int REF_1_KHZ    = 1_000;
  localparam int REF_100_KHZ  = 100_000;
  localparam int REF_900_KHZ  = 900_000;
  localparam int REF1_CYCLES   = CLK_HZ / REF_1_KHZ;
  localparam int REF100_CYCLES = CLK_HZ / REF_100_KHZ;
  localparam int REF900_CYCLES = CLK_HZ / REF_900_KHZ;

  typedef enum logic [1:0] {
    FGC_IDLE,
    FGC_ARMED,
    FGC_OPEN
  } fgc_state_t;
endpackage

// [rtl/fgc_counter.sv]
// gate-controlled frequency counter: IF counting and external-gate counting
// assumes pins already synchronous to clk_i; peripheral write/read strobes one cycle
//
// Function
// - pin select bits 1:0, 11 prohibited
// - counting starts only on start command; open gate time in IF mode counts without one
// - IF mode: status flag reports end
// - external-gate mode: status not completion indicator; here the flag falls at the closing gate edge as in IF mode
// - sixteen-bit binary up-counter, both functions
// - IF mode counts pin only gate open
// - direct mode counts pin undivided
// - halved mode divides pin by two
// - external mode counts reference while gate open
// - counter saturates at all ones
// - count read only via data buffer
// - bit1 one starts active function
// - IF gate opens next tick, 1/4/8 ms
// - start sets flag at once; gate close clears
// - external gate rising edge to next rising
`timescale 1ns/1ps
module fgc_counter
  import fgc_pkg::*;
#(
  parameter int TICK_CYC  = TICK_CYCLES,
  parameter int REF1_CYC  = REF1_CYCLES,
  parameter int REF100_CYC = REF100_CYCLES,
  parameter int REF900_CYC = REF900_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       periph_wr_i,
  input  wire logic [7:0] periph_addr_i,
  input  wire logic [3:0] periph_wdata_i,
  input  wire logic       periph_rd_i,
  output logic      [3:0] periph_rdata_o,
  output logic     [15:0] data_buffer_o,
  output logic            gate_open_flag_o,
  input  wire logic       direct_pin_i,
  input  wire logic       halved_pin_i,
  input  wire logic       gate_pin_zero_i,
  input  wire logic       gate_pin_one_i
);

  // ==========================================================
  // registers and strobes
  logic [1:0]  gate_pin_sel_ff;
  logic [3:0]  mode_sel_ff;
  logic        wr_ctrl;
  logic        count_start_strobe;
  logic        count_clear_strobe;

  assign wr_ctrl            = periph_wr_i && (periph_addr_i == ADDR_COUNTER_CTRL);
  // no storage behind the control register: pure strobes
  assign count_start_strobe = wr_ctrl && periph_wdata_i[BIT_START];
  assign count_clear_strobe = wr_ctrl && periph_wdata_i[BIT_CLEAR];

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      gate_pin_sel_ff <= PIN_NONE;
    end else if (periph_wr_i && periph_addr_i == ADDR_GATE_PIN_SEL) begin
      // prohibited code is stored as written; it routes no pin
      gate_pin_sel_ff <= periph_wdata_i[BIT_SEL_HI:BIT_SEL_LO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mode_sel_ff <= RST_NIBBLE;
    end else if (periph_wr_i && periph_addr_i == ADDR_MODE_SEL) begin
      mode_sel_ff <= periph_wdata_i;
    end
  end

  logic [1:0] func_sel;
  logic [1:0] ck_sel;
  logic       ext_mode;
  assign func_sel = mode_sel_ff[3:2];
  assign ck_sel   = mode_sel_ff[1:0];
  assign ext_mode = (func_sel == FN_EXT_GATE);

  // ==========================================================
  // 1 kHz tick and reference frequency
  logic [31:0] tick_cnt_ff;
  logic        tick;
  assign tick = (tick_cnt_ff == 32'(TICK_CYC - 1));
  always_ff @(posedge clk_i) begin
    if (!resetn_i || tick) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h1;
    end
  end

  logic [31:0] ref_cnt_ff;
  logic [31:0] ref_len;
  logic        ref_pulse;
  always_comb begin
    unique case (ck_sel)
      CK_1MS:  ref_len = 32'(REF1_CYC);
      CK_4MS:  ref_len = 32'(REF100_CYC);
      default: ref_len = 32'(REF900_CYC);  // open/prohibited fall back
    endcase
  end
  assign ref_pulse = (ref_cnt_ff >= ref_len - 32'h1);
  always_ff @(posedge clk_i) begin
    if (!resetn_i || ref_pulse) begin
      ref_cnt_ff <= '0;
    end else begin
      ref_cnt_ff <= ref_cnt_ff + 32'h1;
    end
  end

  // ==========================================================
  // input selection and edge detection
  logic gate_pin;
  always_comb begin
    unique case (gate_pin_sel_ff)
      PIN_ZERO: gate_pin = gate_pin_zero_i;
      PIN_ONE:  gate_pin = gate_pin_one_i;
      default:  gate_pin = 1'b0;
    endcase
  end

  logic if_pin;
  assign if_pin = (func_sel == FN_DIRECT) ? direct_pin_i : halved_pin_i;

  logic if_pin_d_ff;
  logic gate_pin_d_ff;
  logic half_ff;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      if_pin_d_ff   <= 1'b0;
      gate_pin_d_ff <= 1'b0;
    end else begin
      if_pin_d_ff   <= if_pin;
      gate_pin_d_ff <= gate_pin;
    end
  end

  logic if_rise;
  logic gate_rise;
  assign if_rise   = if_pin && !if_pin_d_ff;
  assign gate_rise = gate_pin && !gate_pin_d_ff;

  // divide-by-two of the halved-mode pin
  always_ff @(posedge clk_i) begin
    if (!resetn_i || count_clear_strobe) begin
      half_ff <= 1'b0;
    end else if (if_rise && func_sel == FN_HALVED) begin
      half_ff <= !half_ff;
    end
  end

  logic if_event;
  always_comb begin
    if (func_sel == FN_HALVED) begin
      if_event = if_rise && half_ff;
    end else begin
      if_event = if_rise;
    end
  end

  // ==========================================================
  // gate control
  fgc_state_t state_ff;
  logic [3:0] ms_left_ff;
  logic [3:0] gate_ms;
  logic       gate_open;
  logic       free_open;

  always_comb begin
    unique case (ck_sel)
      CK_1MS:  gate_ms = 4'(GATE_1_MS);
      CK_4MS:  gate_ms = 4'(GATE_4_MS);
      default: gate_ms = 4'(GATE_8_MS);
    endcase
  end

  // "open" gate time needs no start command
  assign free_open = !ext_mode && ck_sel == CK_OPEN;
  assign gate_open = (state_ff == FGC_OPEN) || free_open;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_ff   <= FGC_IDLE;
      ms_left_ff <= 4'h0;
    end else if (count_start_strobe && !free_open) begin
      state_ff <= FGC_ARMED;
    end else begin
      unique case (state_ff)
        FGC_IDLE: begin
          state_ff <= FGC_IDLE;
        end
        FGC_ARMED: begin
          if (ext_mode && gate_rise) begin
            state_ff <= FGC_OPEN;
          end else if (!ext_mode && tick) begin
            state_ff   <= FGC_OPEN;
            ms_left_ff <= gate_ms;
          end
        end
        FGC_OPEN: begin
          if (ext_mode && gate_rise) begin
            state_ff <= FGC_IDLE;
          end else if (!ext_mode && tick) begin
            if (ms_left_ff == 4'h1) begin
              state_ff <= FGC_IDLE;
            end
            ms_left_ff <= ms_left_ff - 4'h1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // status flag: set at start, cleared by gate close
  // in external mode it also falls only on the closing edge, so
  // software cannot tell armed from open by it
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      gate_open_flag_o <= 1'b0;
    end else if (count_start_strobe && !free_open) begin
      gate_open_flag_o <= 1'b1;
    end else if (state_ff == FGC_IDLE) begin
      gate_open_flag_o <= 1'b0;
    end
  end

  // ==========================================================
  // 16-bit saturating counter
  logic [15:0] count_value_register_ff;
  logic        cnt_event;
  assign cnt_event = gate_open && (ext_mode ? ref_pulse : if_event);

  always_ff @(posedge clk_i) begin
    if (!resetn_i || count_clear_strobe) begin
      count_value_register_ff <= CNT_ZERO;
    end else if (cnt_event && count_value_register_ff != CNT_MAX) begin
      count_value_register_ff <= count_value_register_ff + 16'h1;
    end
  end

  // ==========================================================
  // reads: nibble registers and data-buffer transfer
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      data_buffer_o <= CNT_ZERO;
    end else if (periph_rd_i && periph_addr_i == ADDR_COUNT_VALUE) begin
      data_buffer_o <= count_value_register_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      periph_rdata_o <= RST_NIBBLE;
    end else if (periph_rd_i) begin
      unique case (periph_addr_i)
        ADDR_GATE_PIN_SEL: periph_rdata_o <= {2'h0, gate_pin_sel_ff};
        ADDR_MODE_SEL:     periph_rdata_o <= mode_sel_ff;
        ADDR_GATE_STATUS:  periph_rdata_o <= {3'h0, gate_open_flag_o};
        default:           periph_rdata_o <= RST_NIBBLE;  // control is write-only
      endcase
    end
  end

endmodule

// [verification/fgc_counter_assertions.sv]
// checker for the frequency gate counter ports
// assumes it is bound onto fgc_counter with the same tick parameter
`timescale 1ns/1ps
module fgc_counter_chk
  import fgc_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        periph_wr_i,
  input wire logic [7:0]  periph_addr_i,
  input wire logic [3:0]  periph_wdata_i,
  input wire logic        periph_rd_i,
  input wire logic [3:0]  periph_rdata_o,
  input wire logic [15:0] data_buffer_o,
  input wire logic        gate_open_flag_o
);
  // ==========================================
  // mode shadow: open-gate setting ignores start
  localparam int GATE_LIM = 9 * TICK_CYC + 4;
  logic [3:0] mode_ff;
  logic       if_mode;
  logic       open_mode;
  logic       wr_ctl;
  logic       start_wr;
  logic       rd_cnt;
  always_ff @(posedge clk_i) begin
    if (!resetn_i)
      mode_ff <= RST_NIBBLE;
    else if (periph_wr_i && periph_addr_i == ADDR_MODE_SEL)
      mode_ff <= periph_wdata_i;
  end
  assign if_mode   = mode_ff[3:2] != FN_EXT_GATE;
  assign open_mode = if_mode && mode_ff[1:0] == CK_OPEN;
  assign wr_ctl    = periph_wr_i && periph_addr_i == ADDR_COUNTER_CTRL;
  assign start_wr  = wr_ctl && periph_wdata_i[BIT_START];
  assign rd_cnt    = periph_rd_i && periph_addr_i == ADDR_COUNT_VALUE;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================
  // properties
  start_flag_a: assert property (start_wr && !open_mode |=> gate_open_flag_o)
    else $error("flag not set by start");
  flag_cause_a: assert property ($rose(gate_open_flag_o) |-> $past(start_wr))
    else $error("flag rose without start");
  ctl_read_a: assert property (periph_rd_i && periph_addr_i == ADDR_COUNTER_CTRL |=> periph_rdata_o == 4'h0)
    else $error("control reads nonzero");
  pinsel_fixed_a: assert property (periph_rd_i && periph_addr_i == ADDR_GATE_PIN_SEL |=> periph_rdata_o[3:2] == 2'h0)
    else $error("pin select upper bits set");
  status_read_a: assert property (periph_rd_i && periph_addr_i == ADDR_GATE_STATUS
    |=> periph_rdata_o[0] == $past(gate_open_flag_o))
    else $error("status bit differs from flag");
  buffer_hold_a: assert property ($changed(data_buffer_o) |-> $past(rd_cnt))
    else $error("buffer moved without read");
  clear_zero_a: assert property ((wr_ctl && periph_wdata_i[BIT_CLEAR] && !gate_open_flag_o && !open_mode)
    ##[1:2] (rd_cnt && !gate_open_flag_o) |=> data_buffer_o == CNT_ZERO)
    else $error("count not cleared");
  if_gate_max_a: assert property ($rose(gate_open_flag_o) && if_mode |-> ##[1:GATE_LIM] !gate_open_flag_o)
    else $error("gate stayed open too long");
endmodule

bind fgc_counter fgc_counter_chk #(.TICK_CYC(TICK_CYC)) u_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .periph_wr_i(periph_wr_i), .periph_addr_i(periph_addr_i),
  .periph_wdata_i(periph_wdata_i), .periph_rd_i(periph_rd_i), .periph_rdata_o(periph_rdata_o),
  .data_buffer_o(data_buffer_o), .gate_open_flag_o(gate_open_flag_o));

// [verification/fgc_src_model.sv]
// signal source model: two IF inputs and one gate waveform
// assumes en_i is low until reset is over; outputs idle low when disabled
`timescale 1ns/1ps
module fgc_src_model (
  input  wire logic clk_i,
  input  wire logic en_i,
  output logic      fast_o,
  output logic      slow_o,
  output logic      gate_o
);
  // ==========================================
  // periods 4, 8 and 64 clocks, changed on the falling edge
  logic [5:0] ph_ff;
  always_ff @(negedge clk_i) begin
    ph_ff <= en_i ? ph_ff + 6'h01 : 6'h00;
  end
  assign fast_o = en_i & ph_ff[1];
  assign slow_o = en_i & ph_ff[2];
  assign gate_o = en_i & ph_ff[5];
endmodule

// [verification/frequency_gate_counter_tb_top.sv]
// testbench: register accesses and measurements on the frequency gate counter
// assumes fgc_pkg, the design and the source model are compiled first
`timescale 1ns/1ps
module frequency_gate_counter_tb_top import fgc_pkg::*; ();
  // ==========================================
  // signals
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        en = 1'b0;
  logic        gsel = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [3:0]  wd = 4'h0;
  logic [3:0]  rdata;
  logic [15:0] dbuf;
  logic        flag, fast, slow, gate;
  logic        sgate = 1'b0;
  logic [15:0] dbuf_sat;
  int          n_tests = 0;
  int          miscompares = 0;
  int          cyc = 0;

  always #10 clk = ~clk;

  // unselected gate pin carries a busy signal so a wrong pick miscounts
  fgc_counter #(.TICK_CYC(20), .REF1_CYC(8), .REF100_CYC(4), .REF900_CYC(2)) dut (
    .clk_i(clk), .resetn_i(resetn), .periph_wr_i(wr), .periph_addr_i(addr), .periph_wdata_i(wd),
    .periph_rd_i(rd), .periph_rdata_o(rdata), .data_buffer_o(dbuf), .gate_open_flag_o(flag),
    .direct_pin_i(fast), .halved_pin_i(slow),
    .gate_pin_zero_i(gsel ? fast : gate), .gate_pin_one_i(gsel ? gate : fast));
  fgc_src_model src (.clk_i(clk), .en_i(en), .fast_o(fast), .slow_o(slow), .gate_o(gate));
  // second counter shares the bus; one reference pulse a clock so a long gate passes all ones
  fgc_counter #(.TICK_CYC(20), .REF1_CYC(8), .REF100_CYC(4), .REF900_CYC(1)) dut_sat (
    .clk_i(clk), .resetn_i(resetn), .periph_wr_i(wr), .periph_addr_i(addr), .periph_wdata_i(wd),
    .periph_rd_i(rd), .periph_rdata_o(), .data_buffer_o(dbuf_sat), .gate_open_flag_o(),
    .direct_pin_i(fast), .halved_pin_i(slow),
    .gate_pin_zero_i(sgate), .gate_pin_one_i(gate));

  // ==========================================
  // access and compare tasks
  task automatic wrap_up;
    if (miscompares == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [3:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
  endtask
  task automatic meas(input logic [3:0] m, input logic [3:0] s, input logic g, input logic [15:0] e);
    int i;
    gsel = g;
    wr_reg(ADDR_GATE_PIN_SEL, s);
    wr_reg(ADDR_MODE_SEL, m);
    wr_reg(ADDR_COUNTER_CTRL, 4'h1);
    rd_reg(ADDR_COUNT_VALUE);
    chk("cleared", CNT_ZERO, dbuf);
    wr_reg(ADDR_COUNTER_CTRL, 4'h2);
    chk("flag up", 16'h0001, {15'h0000, flag});
    for (i = 0; i < 400 && flag === 1'b1; i++)
      @(negedge clk);
    rd_reg(ADDR_GATE_STATUS);
    chk("status", 16'h0000, {12'h000, rdata});
    rd_reg(ADDR_COUNT_VALUE);
    chk("count", e, dbuf);
    wr_reg(ADDR_COUNTER_CTRL, 4'h0);
    rd_reg(ADDR_COUNT_VALUE);
    chk("kept", e, dbuf);
  endtask

  always @(posedge clk) begin
    cyc++;
    // tests take about 67k cycles, most of it the saturation run
    if (cyc == 90000) begin
      miscompares++;
      wrap_up;
    end
  end

  // ==========================================
  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    en = 1'b1;
    rd_reg(ADDR_GATE_PIN_SEL);
    chk("sel reset", 16'h0000, {12'h000, rdata});
    rd_reg(ADDR_MODE_SEL);
    chk("mode reset", 16'h0000, {12'h000, rdata});
    wr_reg(ADDR_GATE_PIN_SEL, 4'hf);
    rd_reg(ADDR_GATE_PIN_SEL);
    chk("sel bits", 16'h0003, {12'h000, rdata});
    rd_reg(ADDR_COUNTER_CTRL);
    chk("ctl read", 16'h0000, {12'h000, rdata});
    rd_reg(8'h55);
    chk("unmapped", 16'h0000, {12'h000, rdata});
    // pins toggle but no start is given
    wr_reg(ADDR_MODE_SEL, 4'h4);
    wr_reg(ADDR_COUNTER_CTRL, 4'h1);
    repeat (60) @(negedge clk);
    chk("idle flag", 16'h0000, {15'h0000, flag});
    rd_reg(ADDR_COUNT_VALUE);
    chk("idle count", CNT_ZERO, dbuf);
    // open gate time: counts with no start, 10 edges in 40 cycles of a 4-cycle pin
    wr_reg(ADDR_MODE_SEL, 4'h7);
    repeat (38) @(negedge clk);
    wr_reg(ADDR_MODE_SEL, 4'h4);
    rd_reg(ADDR_COUNT_VALUE);
    chk("open count", 16'd10, dbuf);
    chk("open flag", 16'h0000, {15'h0000, flag});
    meas(4'h4, 4'h0, 1'b0, 16'd5);
    meas(4'h6, 4'h0, 1'b0, 16'd40);
    meas(4'h9, 4'h0, 1'b0, 16'd5);
    meas(4'hd, 4'h0, 1'b0, 16'd10);
    meas(4'h1, 4'h1, 1'b0, 16'd16);
    meas(4'h0, 4'h2, 1'b1, 16'd8);
    meas(4'h2, 4'h1, 1'b0, 16'd32);
    // long external gate: over 65536 reference pulses must stop at all ones
    wr_reg(ADDR_GATE_PIN_SEL, 4'h1);
    wr_reg(ADDR_MODE_SEL, 4'h2);
    wr_reg(ADDR_COUNTER_CTRL, 4'h1);
    wr_reg(ADDR_COUNTER_CTRL, 4'h2);
    repeat (4) @(negedge clk);
    sgate = 1'b1;
    repeat (8) @(negedge clk);
    sgate = 1'b0;
    repeat (66000) @(negedge clk);
    sgate = 1'b1;
    repeat (4) @(negedge clk);
    rd_reg(ADDR_COUNT_VALUE);
    chk("saturated", CNT_MAX, dbuf_sat);
    wrap_up;
  end
endmodule
